/* quad_dac_device.sv */
// Quad DAC serial receiver, command decode and channel registers
// What this block does
// - Command byte: ext addr, mode, pick, powerdown flag
// - Mode 00 writes only staging register
// - Pick 00..11 selects channel A..D
// - Mode 11, pick high 0: stage to outputs
// - Flag 0: first data byte is code
// - Flag 1: data bits 7:6 powerdown code
// - Second data byte ignored but required
// - Update at ack fall after second byte
// - Load pin rise copies all staging registers
// - Pulse load pin only after staging written
// - Staging register: two pd bits, eight code
// - Output register: same split, drives output
// - Addressed as receiver with 7-bit address
// - Mode 01 writes staging and output
// - Mode 10: selected new, others from staging
// - Mode 11, pick high 1: all new
// - Mode 11 ignores ext address and pick low bit
//
// Added by the designer: the APB register port and the address map.
`include "qdac_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module quad_dac_device (
    input wire logic pclk,
    input wire logic presetn,
    two_wire_if.slave bus,
    input wire logic [1:0] bus_addr_pins,
    input wire logic [1:0] ext_addr_pins,
    output var logic [9:0] staging_reg [4],
    output var logic [9:0] output_channel [4],
    output var logic update_pulse
);
    // Three-stage synchronisers
    logic [2:0] scl_sy_q;
    logic [2:0] sda_sy_q;
    logic [2:0] ld_sy_q;
    // Filtered levels
    logic scl_q;
    logic sda_q;
    logic ld_q;
    // Receiver state
    qdac_pkg::dev_state_t st_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] command_byte;
    logic [7:0] upper_data_byte;
    logic ack_q;
    logic sda_o_q;
    // Decoded events
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    logic ld_rise;
    logic start_ev;
    logic stop_ev;
    logic addr_hit;
    logic ext_ok;
    logic upd;
    logic [1:0] mode;
    logic [1:0] pick;

    // Shift pins through three flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sy_q <= 3'h7;
            sda_sy_q <= 3'h7;
            ld_sy_q <= 3'h0;
        end else begin
            scl_sy_q <= {scl_sy_q[1:0], bus.scl};
            sda_sy_q <= {sda_sy_q[1:0], bus.sda};
            ld_sy_q <= {ld_sy_q[1:0], bus.async_load_input};
        end
    end

    // Accept a level once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ld_q <= 1'b0;
        end else begin
            if (scl_sy_q[1] == scl_sy_q[2]) scl_q <= scl_sy_q[2];
            if (sda_sy_q[1] == sda_sy_q[2]) sda_q <= sda_sy_q[2];
            if (ld_sy_q[1] == ld_sy_q[2]) ld_q <= ld_sy_q[2];
        end
    end

    // Edge and condition decode
    always_comb begin
        scl_rise = (scl_sy_q[1] == scl_sy_q[2]) & scl_sy_q[2] & ~scl_q;
        scl_fall = (scl_sy_q[1] == scl_sy_q[2]) & ~scl_sy_q[2] & scl_q;
        sda_rise = (sda_sy_q[1] == sda_sy_q[2]) & sda_sy_q[2] & ~sda_q;
        sda_fall = (sda_sy_q[1] == sda_sy_q[2]) & ~sda_sy_q[2] & sda_q;
        ld_rise = (ld_sy_q[1] == ld_sy_q[2]) & ld_sy_q[2] & ~ld_q;
        start_ev = sda_fall & scl_q & ~scl_fall;
        stop_ev = sda_rise & scl_q & ~scl_fall;
        // Fixed prefix, address pins, write direction
        addr_hit = shift_q == {`DEV_ADDR_PREFIX, bus_addr_pins, 1'b0};
        // Field split of the stored command
        mode = command_byte[`CB_MODE_HI:`CB_MODE_LO];
        pick = command_byte[`CB_PICK_HI:`CB_PICK_LO];
        // Broadcast acts on any extended address
        ext_ok = (mode == `MODE_BCAST) ||
                 (command_byte[`CB_EXT_HI:`CB_EXT_LO] == ext_addr_pins);
        // Only the ack after the second data byte updates
        upd = scl_fall & (st_q == qdac_pkg::D_ACK_L) & ext_ok;
    end

    // Byte receiver and acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= qdac_pkg::D_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
        end else if (stop_ev) begin
            // Stop ends the frame
            st_q <= qdac_pkg::D_IDLE;
            ack_q <= 1'b0;
        end else if (start_ev) begin
            // Start or repeated start opens address byte
            st_q <= qdac_pkg::D_ADDR;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else begin
            unique case (st_q)
                qdac_pkg::D_IDLE: begin
                    bit_cnt_q <= 4'h0;
                end
                qdac_pkg::D_ADDR, qdac_pkg::D_CTRL, qdac_pkg::D_MSB,
                qdac_pkg::D_LSB: begin
                    // Sample data on the rising clock
                    if (scl_rise && bit_cnt_q < 4'h8) begin
                        shift_q <= {shift_q[6:0], sda_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        // Byte done: hold data low for ack
                        ack_q <= (st_q != qdac_pkg::D_ADDR) || addr_hit;
                        unique case (st_q)
                            qdac_pkg::D_ADDR: st_q <= qdac_pkg::D_ACK_A;
                            qdac_pkg::D_CTRL: st_q <= qdac_pkg::D_ACK_C;
                            qdac_pkg::D_MSB: st_q <= qdac_pkg::D_ACK_M;
                            default: st_q <= qdac_pkg::D_ACK_L;
                        endcase
                    end
                end
                default: begin
                    // Ack slot ends on the next falling clock
                    if (scl_fall) begin
                        ack_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        unique case (st_q)
                            qdac_pkg::D_ACK_A:
                                st_q <= ack_q ? qdac_pkg::D_CTRL : qdac_pkg::D_IDLE;
                            qdac_pkg::D_ACK_C: st_q <= qdac_pkg::D_MSB;
                            qdac_pkg::D_ACK_M: st_q <= qdac_pkg::D_LSB;
                            default: st_q <= qdac_pkg::D_MSB;
                        endcase
                    end
                end
            endcase
        end
    end

    // Latch command and upper data bytes when complete
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_byte <= 8'h00;
            upper_data_byte <= 8'h00;
        end else if (scl_fall && bit_cnt_q == 4'h8) begin
            if (st_q == qdac_pkg::D_CTRL) command_byte <= shift_q;
            if (st_q == qdac_pkg::D_MSB) upper_data_byte <= shift_q;
        end
    end

    // Open-drain data output; level low only ever driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_o_q <= 1'b0;
            update_pulse <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
            update_pulse <= upd;
        end
    end
    assign bus.sda_s_o = sda_o_q;
    assign bus.sda_s_oe = ack_q;

    // Per-channel staging and output registers
    for (genvar i = 0; i < 4; i++) begin : g_chan
        logic sel_me;
        logic stage_new;
        logic out_new;
        logic out_copy;
        logic [9:0] new_val;
        always_comb begin
            sel_me = pick == 2'(i);
            stage_new = upd & (((mode != `MODE_BCAST) & sel_me) |
                               ((mode == `MODE_BCAST) & pick[1]));
            out_new = upd & ((((mode == `MODE_SINGLE) | (mode == `MODE_SYNC)) & sel_me) |
                             ((mode == `MODE_BCAST) & pick[1]));
            out_copy = ld_rise |
                       (upd & (((mode == `MODE_SYNC) & ~sel_me) |
                               ((mode == `MODE_BCAST) & ~pick[1])));
            // Powerdown code keeps the stored conversion code
            new_val = command_byte[`CB_PD] ? {upper_data_byte[7:6], staging_reg[i][7:0]}
                                           : {2'b00, upper_data_byte};
        end
        // Staging register
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                staging_reg[i] <= `CHAN_RST;
            end else if (stage_new) begin
                staging_reg[i] <= new_val;
            end
        end
        // Output register; new data wins over copy
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                output_channel[i] <= `CHAN_RST;
            end else if (out_new) begin
                output_channel[i] <= new_val;
            end else if (out_copy) begin
                output_channel[i] <= staging_reg[i];
            end
        end
    end
endmodule : quad_dac_device
`default_nettype wire

/* qdac_defs.svh */
// Shared constants for the quad DAC command link and its controller
`ifndef QDAC_DEFS_SVH
`define QDAC_DEFS_SVH
// System clock period in ns
`define PCLK_NS 50
// Serial clock period made by the controller, in ns
`define SCL_PERIOD_NS 800
// Serial clock period in pclk cycles
`define SCL_PERIOD_CYC (`SCL_PERIOD_NS / `PCLK_NS)
// Phase points within one serial clock period
`define SCL_HALF_CYC (`SCL_PERIOD_CYC / 2)
`define SCL_QTR_CYC (`SCL_PERIOD_CYC / 4)
// Fixed upper five bits of the 7-bit bus address
`define DEV_ADDR_PREFIX 5'h13
// Command byte field positions
`define CB_EXT_HI 7
`define CB_EXT_LO 6
`define CB_MODE_HI 5
`define CB_MODE_LO 4
`define CB_PICK_HI 2
`define CB_PICK_LO 1
`define CB_PD 0
// Update modes
`define MODE_STAGE 2'h0
`define MODE_SINGLE 2'h1
`define MODE_SYNC 2'h2
`define MODE_BCAST 2'h3
// Channel register reset value
`define CHAN_RST 10'h000
// Controller register offsets
`define REG_CTRL 12'h000
`define REG_FRAME 12'h004
`define REG_STATUS 12'h008
// Control register bits
`define CTRL_GO 0
`define CTRL_LOAD 1
// Status register bits
`define STAT_BUSY 0
`define STAT_NACK 1
`endif

/* qdac_pkg.sv */
// Types shared by both ends of the quad DAC link
package qdac_pkg;
    // Receiver byte states, Gray from D_IDLE through D_ACK_L
    typedef enum logic [3:0] {
        D_IDLE = 4'h0,
        D_ADDR = 4'h1,
        D_ACK_A = 4'h3,
        D_CTRL = 4'h2,
        D_ACK_C = 4'h6,
        D_MSB = 4'h7,
        D_ACK_M = 4'h5,
        D_LSB = 4'h4,
        D_ACK_L = 4'hc
    } dev_state_t;
    // Controller frame states
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_START = 2'h1,
        M_BITS = 2'h3,
        M_STOP = 2'h2
    } mst_state_t;
endpackage : qdac_pkg

/* two_wire_if.sv */
// Two-wire link plus load pin between controller and DAC
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic async_load_input;
    wire logic sda;
    // Open-drain wired-AND with pull-up
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport master (output scl, output sda_m_o, output sda_m_oe,
                    output async_load_input, input sda);
    modport slave (input scl, input sda, input async_load_input,
                   output sda_s_o, output sda_s_oe);
endinterface : two_wire_if
`default_nettype wire

/* quad_dac_ctrl.sv */
// APB-driven two-wire controller that writes the quad DAC
`include "qdac_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module quad_dac_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    two_wire_if.master bus
);
    // Frame: address, command, upper data
    logic [22:0] frame_q;
    logic busy_q;
    logic nack_q;
    logic load_q;
    logic go;
    logic wr;
    // Bus outputs
    logic scl_q;
    logic sda_oe_q;
    logic sda_o_q;
    // Data input synchroniser and filtered level
    logic [2:0] sda_sy_q;
    logic sda_q;
    // Sequencer
    qdac_pkg::mst_state_t st_q;
    logic [3:0] cnt_q;
    logic [1:0] byte_q;
    logic [3:0] bit_q;
    logic [31:0] bits;
    logic cur_bit;

    // Write decode at the access edge
    assign wr = psel & penable & pready & pwrite;
    assign go = wr & (paddr == `REG_CTRL) & pwdata[`CTRL_GO] & ~busy_q;

    // APB answer: one wait-free access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & (paddr != `REG_CTRL) &
                       (paddr != `REG_FRAME) & (paddr != `REG_STATUS);
            unique case (paddr)
                `REG_CTRL: prdata <= {30'h0, load_q, 1'b0};
                `REG_FRAME: prdata <= {9'h0, frame_q};
                `REG_STATUS: prdata <= {30'h0, nack_q, busy_q};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_q <= 23'h0;
            load_q <= 1'b0;
        end else if (wr) begin
            if (paddr == `REG_FRAME) frame_q <= pwdata[22:0];
            // Software raises the load pin once staging is written
            if (paddr == `REG_CTRL) load_q <= pwdata[`CTRL_LOAD];
        end
    end
    assign bus.async_load_input = load_q;

    // Data line synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_sy_q <= 3'h7;
            sda_q <= 1'b1;
        end else begin
            sda_sy_q <= {sda_sy_q[1:0], bus.sda};
            if (sda_sy_q[1] == sda_sy_q[2]) sda_q <= sda_sy_q[2];
        end
    end

    // Bit stream: 7-bit address and write, command, upper, lower byte
    assign bits = {frame_q[22:16], 1'b0, frame_q[15:8], frame_q[7:0], 8'h00};
    assign cur_bit = bits[5'd31 - {byte_q, bit_q[2:0]}];

    // Frame sequencer and pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= qdac_pkg::M_IDLE;
            cnt_q <= 4'h0;
            byte_q <= 2'h0;
            bit_q <= 4'h0;
            scl_q <= 1'b1;
            sda_oe_q <= 1'b0;
            sda_o_q <= 1'b0;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0;
            cnt_q <= cnt_q + 4'h1;
            unique case (st_q)
                qdac_pkg::M_IDLE: begin
                    cnt_q <= 4'h0;
                    if (go) begin
                        st_q <= qdac_pkg::M_START;
                        busy_q <= 1'b1;
                        nack_q <= 1'b0;
                        byte_q <= 2'h0;
                        bit_q <= 4'h0;
                    end
                end
                qdac_pkg::M_START: begin
                    // Data falls while clock high
                    if (cnt_q == 4'(`SCL_HALF_CYC)) sda_oe_q <= 1'b1;
                    if (cnt_q == 4'(`SCL_PERIOD_CYC - 1)) begin
                        scl_q <= 1'b0;
                        st_q <= qdac_pkg::M_BITS;
                    end
                end
                qdac_pkg::M_BITS: begin
                    // Data changes mid-low; ack slot released
                    if (cnt_q == 4'(`SCL_QTR_CYC))
                        sda_oe_q <= (bit_q == 4'h8) ? 1'b0 : ~cur_bit;
                    if (cnt_q == 4'(`SCL_HALF_CYC)) scl_q <= 1'b1;
                    if (cnt_q == 4'(`SCL_PERIOD_CYC - 1)) begin
                        scl_q <= 1'b0;
                        if (bit_q != 4'h8) begin
                            bit_q <= bit_q + 4'h1;
                        end else if (sda_q) begin
                            // No acknowledge: abandon the frame
                            nack_q <= 1'b1;
                            st_q <= qdac_pkg::M_STOP;
                        end else if (byte_q == 2'h3) begin
                            // Lower byte acked: device updated
                            st_q <= qdac_pkg::M_STOP;
                        end else begin
                            byte_q <= byte_q + 2'h1;
                            bit_q <= 4'h0;
                        end
                    end
                end
                default: begin
                    // Stop: data rises while clock high
                    if (cnt_q == 4'(`SCL_QTR_CYC)) sda_oe_q <= 1'b1;
                    if (cnt_q == 4'(`SCL_HALF_CYC)) scl_q <= 1'b1;
                    if (cnt_q == 4'(`SCL_HALF_CYC + `SCL_QTR_CYC)) sda_oe_q <= 1'b0;
                    if (cnt_q == 4'(`SCL_PERIOD_CYC - 1)) begin
                        st_q <= qdac_pkg::M_IDLE;
                        busy_q <= 1'b0;
                    end
                end
            endcase
        end
    end
    assign bus.scl = scl_q;
    assign bus.sda_m_oe = sda_oe_q;
    assign bus.sda_m_o = sda_o_q;
endmodule : quad_dac_ctrl
`default_nettype wire

/* quad_dac_command_update_props.sv */
// Link checker for the quad DAC two-wire interface
`timescale 1ns/1ps
`default_nettype none
module quad_dac_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic async_load_input
);
    // All checks on the system clock, quiet in reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Controller only ever pulls the data line low
    a_master_pulls_low: assert property (sda_m_oe |-> !sda_m_o)
        else $error("controller drives data high");
    // Receiver only ever pulls the data line low
    a_device_pulls_low: assert property (sda_s_oe |-> !sda_s_o)
        else $error("receiver drives data high");
    // Serial clock high phase lasts at least seven cycles
    a_scl_high_len: assert property ($rose(scl) |-> scl [*7])
        else $error("serial clock high phase too short");
    // Serial clock low phase long enough for the receiver
    a_scl_low_len: assert property ($fell(scl) |-> !scl [*5])
        else $error("serial clock low phase too short");
    // Acknowledge held about one bit period, then released
    a_ack_hold_len: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8] ##[1:16] !sda_s_oe)
        else $error("acknowledge length wrong");
    // Acknowledge starts only while the clock is low
    a_ack_start_low: assert property ($rose(sda_s_oe) |-> !scl)
        else $error("acknowledge started with clock high");
    // Acknowledge released only while the clock is low
    a_ack_end_low: assert property ($fell(sda_s_oe) |-> !scl)
        else $error("acknowledge released with clock high");
    // Receiver never moves the data line while the clock is high
    a_ack_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("receiver changed data with clock high");
    // Start condition holds the clock high afterwards
    a_start_hold: assert property (scl && $fell(sda) |-> scl [*4])
        else $error("start condition hold too short");
    // Load pin rises only with the link idle
    a_load_when_idle: assert property ($rose(async_load_input) |-> scl && sda)
        else $error("load pin raised during a frame");

    // Main scenarios reached
    c_ack_seen: cover property ($rose(sda_s_oe));
    c_load_seen: cover property ($rose(async_load_input));
    c_start_seen: cover property (scl && $fell(sda));
endmodule : quad_dac_link_props
`default_nettype wire

/* quad_dac_command_update_tb.sv */
// Testbench for the quad DAC controller and receiver pair
`include "qdac_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module quad_dac_command_update_tb;
    localparam logic [6:0] DEV_ADR = {`DEV_ADDR_PREFIX, 2'h1}; // Strapped bus address
    localparam logic [1:0] EXT = 2'h2; // Strapped extended address
    logic pclk; // System clock
    logic presetn; // Active-low reset
    logic psel, penable, pwrite; // APB request
    logic [11:0] paddr; // APB address
    logic [31:0] pwdata, prdata, rdata; // APB data and captured read
    logic pready, pslverr, slverr; // APB answer and captured error
    logic [9:0] staging_reg [4]; // Receiver staging view
    logic [9:0] output_channel [4]; // Receiver output view
    logic [9:0] exp_stg [4]; // Expected staging
    logic [9:0] exp_out [4]; // Expected outputs
    logic update_pulse; // Serial update strobe
    logic ld; // Load pin level to request
    int pulses = 0; // Count of update strobes
    int bad_count = 0; // Mismatches
    int check_count = 0; // Comparisons

    two_wire_if bus_if ();

    quad_dac_ctrl i_quad_dac_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));

    quad_dac_device i_quad_dac_device (.pclk(pclk), .presetn(presetn), .bus(bus_if),
        .bus_addr_pins(2'h1), .ext_addr_pins(EXT), .staging_reg(staging_reg),
        .output_channel(output_channel), .update_pulse(update_pulse));

    quad_dac_link_props i_quad_dac_link_props (.pclk(pclk), .presetn(presetn),
        .scl(bus_if.scl), .sda(bus_if.sda), .sda_m_o(bus_if.sda_m_o),
        .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
        .async_load_input(bus_if.async_load_input));

    // Free-running 20 MHz clock
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    // Count serial update strobes
    always @(posedge pclk) begin
        if (update_pulse === 1'h1) begin
            pulses <= pulses + 1;
        end
    end

    // Verdict and end of run
    task automatic final_report;
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Compare one value and report a mismatch
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Send one frame, wait for idle, update the expected registers
    task automatic send(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] d);
        int n;
        int p0;
        logic hit;
        logic [9:0] nv;
        p0 = pulses;
        hit = (ad == DEV_ADR) && (c[5:4] == `MODE_BCAST || c[7:6] == EXT);
        apb(1'h1, `REG_FRAME, {9'h000, ad, c, d});
        apb(1'h1, `REG_CTRL, {30'h0, ld, 1'h1});
        n = 0;
        do begin
            apb(1'h0, `REG_STATUS, 32'h0);
            n++;
        end while (rdata[0] !== 1'h0 && n < 400);
        repeat (8) @(posedge pclk);
        chk("busy", {31'h0, rdata[0]}, 32'h0);
        chk("update count", 32'(pulses - p0), {31'h0, hit});
        for (int k = 0; k < 4; k++) begin
            nv = c[0] ? {d[7:6], exp_stg[k][7:0]} : {2'h0, d};
            if (!hit) begin
                // No change
            end else if (c[5:4] == `MODE_BCAST && !c[2]) begin
                exp_out[k] = exp_stg[k];
            end else if ((c[5:4] == `MODE_BCAST) || (k == int'(c[2:1]))) begin
                exp_stg[k] = nv;
                if (c[5:4] != `MODE_STAGE) begin
                    exp_out[k] = nv;
                end
            end else if (c[5:4] == `MODE_SYNC) begin
                exp_out[k] = exp_stg[k];
            end
        end
    endtask : send

    // Compare all channel registers with the expectation
    task automatic cmp_all;
        for (int k = 0; k < 4; k++) begin
            chk("staging", {22'h0, staging_reg[k]}, {22'h0, exp_stg[k]});
            chk("output", {22'h0, output_channel[k]}, {22'h0, exp_out[k]});
        end
    endtask : cmp_all

    // Main sequence
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ld = 1'h0;
        exp_stg = '{default: `CHAN_RST};
        exp_out = '{default: `CHAN_RST};
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        cmp_all();
        apb(1'h0, `REG_STATUS, 32'h0);
        chk("status", rdata, 32'h0);
        send(DEV_ADR, {EXT, 2'h0, 1'h0, 2'h1, 1'h0}, 8'h5a);
        cmp_all();
        for (int k = 0; k < 4; k++) begin
            send(DEV_ADR, {EXT, 2'h1, 1'h0, 2'(k), 1'h0}, 8'h10 + 8'(k));
            cmp_all();
        end
        send(DEV_ADR, {EXT, 2'h0, 1'h0, 2'h3, 1'h0}, 8'h99);
        send(DEV_ADR, {EXT, 2'h2, 1'h0, 2'h0, 1'h0}, 8'h77);
        cmp_all();
        send(DEV_ADR, {EXT, 2'h0, 1'h0, 2'h1, 1'h0}, 8'h21);
        send(DEV_ADR, {2'h1, 2'h3, 1'h0, 2'h1, 1'h1}, 8'hff);
        cmp_all();
        send(DEV_ADR, {2'h1, 2'h1, 1'h0, 2'h0, 1'h0}, 8'hee);
        cmp_all();
        send(DEV_ADR, {2'h1, 2'h3, 1'h0, 2'h2, 1'h0}, 8'h3c);
        cmp_all();
        send(DEV_ADR, {EXT, 2'h0, 1'h0, 2'h0, 1'h0}, 8'h42);
        ld = 1'h1;
        apb(1'h1, `REG_CTRL, {30'h0, ld, 1'h0});
        repeat (8) @(posedge pclk);
        exp_out = exp_stg;
        cmp_all();
        apb(1'h0, `REG_CTRL, 32'h0);
        chk("control", rdata, 32'h2);
        ld = 1'h0;
        apb(1'h1, `REG_CTRL, 32'h0);
        send({`DEV_ADDR_PREFIX, 2'h2}, {EXT, 2'h1, 1'h0, 2'h0, 1'h0}, 8'h55);
        chk("nack", {31'h0, rdata[1]}, 32'h1);
        cmp_all();
        send(DEV_ADR, {EXT, 2'h1, 1'h0, 2'h2, 1'h1}, 8'h80);
        cmp_all();
        apb(1'h1, 12'h00c, 32'h1);
        chk("slverr", {31'h0, slverr}, 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped read", rdata, 32'h0);
        final_report();
    end

    // Watchdog against a hung run
    initial begin
        #3000000;
        bad_count++;
        final_report();
    end
endmodule : quad_dac_command_update_tb
`default_nettype wire
